// ==== ccm_clock_select.v ====
// Functional notes
// - every cpu clock edge, rising or falling, is a timing step: one half-cycle
// - clock generation path is chosen by bits 7..5 of the latched port register
// - at long reset the latched register loads the upper port pins; board sets code
// - pll factors: 111=4, 110=3, 101=2, 100=5, 010=1.5, 000=2.5
// - code 011 disables the pll; cpu clock follows the oscillator directly
// - code 001 derives the cpu clock through a two-to-one prescaler
// - prescaler mode: each cpu high and low phase lasts one oscillator period
// - pll codes enable the pll; cpu clock is oscillator times factor
// - pll resyncs every factor-count oscillator transitions, adjusting gradually
// - direct drive: half-cycles follow input duty, two span one input period
// - waitstate time is two half-cycles times fifteen minus cycle-time value
// - ale extension one half-cycle times value; tristate two times one minus value
`timescale 1ns/10ps
`include "ccm_defs.vh"
module ccm_clock_select #(
  parameter PW = 16,
  parameter TW = 5
) (
  input wire clk,
  input wire rst_n,
  input wire osc_in,
  input wire [7:0] upper_port0_pins,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata_r,
  output reg hreadyout_r,
  output reg hresp_r,
  output reg cpu_clk_r,
  output reg half_cycle_tick_r,
  output reg pll_enable_r,
  output reg direct_drive_r,
  output reg prescaler_on_r,
  output reg clk_valid_r,
  output reg [2:0] clock_gen_code_r,
  output reg [7:0] reset_latched_port_high_r,
  output wire ale_ext_done,
  output wire waitstate_done,
  output wire tristate_done
);

  // reset release through two flops
  reg [1:0] rst_sync_r;
  wire rst_i_n;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_i_n = rst_sync_r[1];

  // pin synchronisers, first stage read only by second
  reg [1:0] osc_sync_r;
  reg [7:0] pin_s1_r;
  reg [7:0] pin_s2_r;
  reg osc_d_r;
  wire osc_lvl;
  wire osc_rise;
  wire osc_edge;

  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      osc_sync_r <= 2'b00;
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      osc_d_r <= 1'b0;
    end else begin
      osc_sync_r <= {osc_sync_r[0], osc_in};
      pin_s1_r <= upper_port0_pins;
      pin_s2_r <= pin_s1_r;
      osc_d_r <= osc_sync_r[1];
    end
  end

  assign osc_lvl = osc_sync_r[1];
  assign osc_rise = osc_lvl & ~osc_d_r;
  assign osc_edge = osc_lvl ^ osc_d_r;

  // one-time capture of the port levels after reset release
  reg [1:0] cap_cnt_r;
  reg code_valid_r;

  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      cap_cnt_r <= 2'h0;
      code_valid_r <= 1'b0;
      reset_latched_port_high_r <= 8'h00;
    end else if (!code_valid_r) begin
      if (cap_cnt_r == `CCM_CAPTURE_DLY) begin
        reset_latched_port_high_r <= pin_s2_r;
        code_valid_r <= 1'b1;
      end else begin
        cap_cnt_r <= cap_cnt_r + 2'h1;
      end
    end
  end

  // mode decode from the captured field
  wire [2:0] code;
  wire is_direct;
  wire is_presc;
  wire is_pll;
  reg [3:0] hx;
  wire [3:0] rs_len;

  assign code = reset_latched_port_high_r[`CCM_CFG_MSB:`CCM_CFG_LSB];
  assign is_direct = (code == `CCM_CODE_DIRECT);
  assign is_presc = (code == `CCM_CODE_PRESC);
  assign is_pll = ~is_direct & ~is_presc;

  // factor in halves per code
  always @* begin
    case (code)
      `CCM_CODE_X4: hx = `CCM_HX_X4;
      `CCM_CODE_X3: hx = `CCM_HX_X3;
      `CCM_CODE_X2: hx = `CCM_HX_X2;
      `CCM_CODE_X5: hx = `CCM_HX_X5;
      `CCM_CODE_X1P5: hx = `CCM_HX_X1P5;
      `CCM_CODE_X2P5: hx = `CCM_HX_X2P5;
      default: hx = `CCM_HX_X4;
    endcase
  end

  // resync interval: factor rounded up, in oscillator transitions
  assign rs_len = (hx + 4'h1) >> 1;

  // oscillator period measurement in clk cycles
  reg [PW-1:0] per_cnt_r;
  reg [PW-1:0] meas_r;
  reg seen_rise_r;
  reg meas_ok_r;

  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      per_cnt_r <= {PW{1'b0}};
      meas_r <= {PW{1'b0}};
      seen_rise_r <= 1'b0;
      meas_ok_r <= 1'b0;
    end else if (osc_rise) begin
      per_cnt_r <= {PW{1'b0}};
      seen_rise_r <= 1'b1;
      if (seen_rise_r) begin
        meas_r <= per_cnt_r + {{(PW-1){1'b0}}, 1'b1};
        meas_ok_r <= 1'b1;
      end
    end else if (per_cnt_r != {PW{1'b1}}) begin
      per_cnt_r <= per_cnt_r + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  // resync point every rs_len oscillator transitions
  reg [3:0] trans_cnt_r;
  wire resync;

  assign resync = osc_edge && (trans_cnt_r == rs_len - 4'h1);

  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      trans_cnt_r <= 4'h0;
    end else if (!is_pll || !code_valid_r) begin
      trans_cnt_r <= 4'h0;
    end else if (osc_edge) begin
      trans_cnt_r <= resync ? 4'h0 : trans_cnt_r + 4'h1;
    end
  end

  // period estimate: first taken whole, later stepped by one
  reg [PW-1:0] p_est_r;
  reg pll_lock_r;

  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      p_est_r <= {PW{1'b0}};
      pll_lock_r <= 1'b0;
    end else if (resync && meas_ok_r) begin
      if (p_est_r == {PW{1'b0}}) begin
        p_est_r <= meas_r;
      end else if (p_est_r < meas_r) begin
        p_est_r <= p_est_r + {{(PW-1){1'b0}}, 1'b1};
      end else if (p_est_r > meas_r) begin
        p_est_r <= p_est_r - {{(PW-1){1'b0}}, 1'b1};
      end
      pll_lock_r <= 1'b1;
    end
  end

  // fractional edge generator: hx edges per estimated period
  reg [PW:0] acc_r;
  wire [PW:0] acc_sum;
  wire pll_step;

  assign acc_sum = acc_r + {{(PW-3){1'b0}}, hx};
  assign pll_step = pll_lock_r && (acc_sum >= {1'b0, p_est_r});

  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      acc_r <= {(PW+1){1'b0}};
    end else if (!pll_lock_r || !is_pll) begin
      acc_r <= {(PW+1){1'b0}};
    end else if (pll_step) begin
      acc_r <= acc_sum - {1'b0, p_est_r};
    end else begin
      acc_r <= acc_sum;
    end
  end

  // cpu clock next value per path
  reg cpu_clk_nxt;
  wire run_ok;

  assign run_ok = code_valid_r && (!is_pll || pll_lock_r);

  always @* begin
    cpu_clk_nxt = 1'b0;
    if (run_ok) begin
      if (is_direct) begin
        cpu_clk_nxt = osc_lvl;
      end else if (is_presc) begin
        cpu_clk_nxt = osc_rise ? ~cpu_clk_r : cpu_clk_r;
      end else begin
        cpu_clk_nxt = pll_step ? ~cpu_clk_r : cpu_clk_r;
      end
    end
  end

  // cpu clock, half-cycle strobe and mode outputs
  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      cpu_clk_r <= 1'b0;
      half_cycle_tick_r <= 1'b0;
      pll_enable_r <= 1'b0;
      direct_drive_r <= 1'b0;
      prescaler_on_r <= 1'b0;
      clk_valid_r <= 1'b0;
      clock_gen_code_r <= 3'h0;
    end else begin
      cpu_clk_r <= cpu_clk_nxt;
      half_cycle_tick_r <= (cpu_clk_nxt != cpu_clk_r);
      pll_enable_r <= code_valid_r & is_pll;
      direct_drive_r <= code_valid_r & is_direct;
      prescaler_on_r <= code_valid_r & is_presc;
      clk_valid_r <= run_ok;
      clock_gen_code_r <= code;
    end
  end

  // bus config register and derived half-cycle counts
  reg [5:0] buscfg_r;
  wire [3:0] cyc_ctl;
  wire tri_ctl;
  wire ale_ctl;
  wire [TW-1:0] ale_hc;
  wire [TW-1:0] wait_hc;
  wire [TW-1:0] tri_hc;
  wire [3:0] wait_pairs;
  wire [TW+4:0] wait_wide;

  assign cyc_ctl = buscfg_r[`CCM_CYC_MSB:`CCM_CYC_LSB];
  assign tri_ctl = buscfg_r[`CCM_TRI_BIT];
  assign ale_ctl = buscfg_r[`CCM_ALE_BIT];
  assign wait_pairs = `CCM_CYC_FULL - cyc_ctl;
  assign ale_hc = {{(TW-1){1'b0}}, ale_ctl};
  assign wait_wide = {{TW{1'b0}}, wait_pairs, 1'b0}; // padded, then cut to timer width
  assign wait_hc = wait_wide[TW-1:0];
  assign tri_hc = {{(TW-2){1'b0}}, ~tri_ctl, 1'b0};

  // ahb-lite slave, zero wait, always okay
  wire ahb_go;
  wire ale_busy;
  wire wait_busy;
  wire tri_busy;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  reg cyc_start_r;
  reg [31:0] rd_mux;

  assign ahb_go = hsel & hready & htrans[1];

  // read data selection
  always @* begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      `CCM_OFS_STATUS: begin
        rd_mux[2:0] = code;
        rd_mux[`CCM_ST_VALID] = code_valid_r;
        rd_mux[`CCM_ST_PLL] = pll_enable_r;
        rd_mux[`CCM_ST_DIRECT] = direct_drive_r;
        rd_mux[`CCM_ST_PRESC] = prescaler_on_r;
        rd_mux[`CCM_ST_LOCK] = pll_lock_r;
        rd_mux[15:8] = reset_latched_port_high_r;
      end
      `CCM_OFS_BUSCFG: rd_mux[5:0] = buscfg_r;
      `CCM_OFS_TIMING: begin
        rd_mux[TW-1:0] = ale_hc;
        rd_mux[TW+7:8] = wait_hc;
        rd_mux[TW+15:16] = tri_hc;
      end
      `CCM_OFS_PERIOD: rd_mux[PW-1:0] = p_est_r;
      `CCM_OFS_CMD: begin
        rd_mux[0] = ale_busy;
        rd_mux[1] = wait_busy;
        rd_mux[2] = tri_busy;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // address phase capture and data phase write
  always @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      buscfg_r <= `CCM_BUSCFG_RST;
      cyc_start_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      cyc_start_r <= 1'b0;
      wr_pend_r <= ahb_go & hwrite & (hsize == 3'h2);
      wr_addr_r <= haddr[7:0];
      if (ahb_go && !hwrite) begin
        hrdata_r <= rd_mux;
      end
      if (wr_pend_r && wr_addr_r == `CCM_OFS_BUSCFG) begin
        buscfg_r <= hwdata[5:0];
      end
      if (wr_pend_r && wr_addr_r == `CCM_OFS_CMD) begin
        cyc_start_r <= hwdata[0];
      end
    end
  end

  // memory cycle phase timers counted in half-cycles
  ccm_half_timer #(.W(TW)) u_ale (
    .clk(clk),
    .rst_n(rst_i_n),
    .start(cyc_start_r),
    .load(ale_hc),
    .tick(half_cycle_tick_r),
    .busy_r(ale_busy),
    .done_r(ale_ext_done)
  );

  ccm_half_timer #(.W(TW)) u_wait (
    .clk(clk),
    .rst_n(rst_i_n),
    .start(cyc_start_r),
    .load(wait_hc),
    .tick(half_cycle_tick_r),
    .busy_r(wait_busy),
    .done_r(waitstate_done)
  );

  ccm_half_timer #(.W(TW)) u_tri (
    .clk(clk),
    .rst_n(rst_i_n),
    .start(cyc_start_r),
    .load(tri_hc),
    .tick(half_cycle_tick_r),
    .busy_r(tri_busy),
    .done_r(tristate_done)
  );

endmodule

// ==== ccm_clock_select_tb.sv ====
`timescale 1ns/10ps
`include "ccm_defs.vh"
`define CHK(g, e) begin tests_run = tests_run + 1; if ((g) !== (e)) begin errors = errors + 1; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module ccm_clock_select_tb;
  // cpu edges per oscillator period, twice the factor, one nibble per code
  localparam [31:0] EDS = 32'h864a_2315;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg hsel = 1'b0;
  reg hwrite = 1'b0;
  reg got_v = 1'b0;
  reg [7:0] pins = 8'h00;
  reg [1:0] htrans = 2'h0;
  reg [31:0] haddr = 32'h0000_0000;
  reg [31:0] hwdata = 32'h0000_0000;
  reg [31:0] got = 32'h0000_0000;
  reg [31:0] seed = 32'hb0b8_5080;
  reg [31:0] rd, ex, e;
  reg [31:0] exp_q[$];
  wire osc, hrdy, cpu_clk, tick, wdone, valid, adone, tdone;
  wire [31:0] hrdata;
  integer errors = 0;
  integer tests_run = 0;
  integer cyc = 0;
  integer n, hi, k, c, i, na, nt;
  ccm_osc_model #(.P(20), .H(7)) u_osc (.clk(clk), .osc(osc));
  ccm_clock_select dut (.clk(clk), .rst_n(rst_n), .osc_in(osc), .upper_port0_pins(pins), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hrdata_r(hrdata), .hreadyout_r(hrdy), .hresp_r(), .cpu_clk_r(cpu_clk), .half_cycle_tick_r(tick),
    .pll_enable_r(), .direct_drive_r(), .prescaler_on_r(), .clk_valid_r(valid), .clock_gen_code_r(),
    .reset_latched_port_high_r(), .ale_ext_done(adone), .waitstate_done(wdone), .tristate_done(tdone));
  always #2 clk = ~clk;
  task give_verdict;
    begin
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      errors = errors + 1;
      give_verdict;
    end
  end
  // result watcher: oldest note against each posted result
  always @(posedge clk) begin
    if (got_v) begin
      ex = exp_q.pop_front();
      `CHK(got, ex)
    end
  end
  task chk(input [31:0] x, input [31:0] v);
    begin
      exp_q.push_back(x);
      got <= v;
      got_v <= 1'b1;
      @(posedge clk);
      got_v <= 1'b0;
      @(posedge clk);
    end
  endtask
  // single ahb-lite transfer, waits on hready in both phases
  task ahb(input [7:0] a, input w, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      rd = hrdata;
    end
  endtask
  // long reset with the code on the top pins
  task boot(input [2:0] cd);
    begin
      k = $random(seed);
      rst_n <= 1'b0;
      pins <= {cd, k[4:0]};
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      n = 0;
      while (valid !== 1'b1 && n < 600) begin
        @(posedge clk);
        n = n + 1;
      end
      chk(32'h1, n < 600);
      repeat (10) @(posedge clk);
    end
  endtask
  // main sequence: every code, then bus timing variables
  initial begin
    for (c = 0; c < 8; c = c + 1) begin
      boot(c[2:0]);
      e = {16'h0000, pins, c != 1 && c != 3, c == 1, c == 3, c != 1 && c != 3, 1'b1, c[2:0]};
      ahb(`CCM_OFS_STATUS, 1'b0, 32'h0000_0000);
      chk(e, rd);
      pins <= ~pins;
      n = 0;
      hi = 0;
      repeat (400) begin
        @(posedge clk);
        n = n + tick;
        hi = hi + cpu_clk;
      end
      k = 20 * EDS[c*4 +: 4];
      chk(32'h1, n >= k - 2 && n <= k + 2);
      if (c == 3) chk(32'h1, hi >= 133 && hi <= 147);
      if (c == 1) chk(32'h1, hi >= 180 && hi <= 220);
      ahb(`CCM_OFS_STATUS, 1'b0, 32'h0000_0000);
      chk({29'h0, c[2:0]}, {29'h0, rd[2:0]});
      ahb(`CCM_OFS_PERIOD, 1'b0, 32'h0000_0000);
      chk((c != 1 && c != 3) ? 32'h0000_0014 : 32'h0000_0000, rd);
    end
    ahb(`CCM_OFS_BUSCFG, 1'b0, 32'h0000_0000);
    chk(32'h0000_001f, rd);
    ahb(8'h40, 1'b0, 32'h0000_0000);
    chk(32'h0000_0000, rd);
    for (i = 0; i < 4; i = i + 1) begin
      k = $random(seed);
      if (i == 0) k[3:0] = 4'hf;
      ahb(`CCM_OFS_BUSCFG, 1'b1, {26'h000_0000, k[5:0]});
      ahb(`CCM_OFS_TIMING, 1'b0, 32'h0000_0000);
      e = {11'h000, k[4] ? 5'h00 : 5'h02, 3'h0, 5'h1e - {k[3:0], 1'b0}, 3'h0, 4'h0, k[5]};
      chk(e, rd);
      ahb(`CCM_OFS_CMD, 1'b1, 32'h0000_0001);
      n = 0;
      hi = 0;
      na = 0;
      nt = 0;
      while (wdone !== 1'b1 && hi < 500) begin
        @(posedge clk);
        n = n + tick;
        hi = hi + 1;
        na = na + adone;
        nt = nt + tdone;
      end
      // let the short ale and tristate timers finish too
      repeat (12) begin
        @(posedge clk);
        na = na + adone;
        nt = nt + tdone;
      end
      e = 30 - 2 * k[3:0];
      chk(32'h1, hi < 500 && n + 1 >= e && n <= e + 1);
      chk(32'h1, na == 1 && nt == 1);
      ahb(`CCM_OFS_CMD, 1'b0, 32'h0000_0000);
      chk(32'h0000_0000, rd);
    end
    give_verdict;
  end
endmodule

// ==== ccm_cs_sva.sv ====
`timescale 1ns/10ps
module ccm_cs_sva (
  input wire clk,
  input wire rst_n,
  input wire osc_in,
  input wire hreadyout_r,
  input wire hresp_r,
  input wire cpu_clk_r,
  input wire half_cycle_tick_r,
  input wire pll_enable_r,
  input wire direct_drive_r,
  input wire prescaler_on_r,
  input wire clk_valid_r,
  input wire [2:0] clock_gen_code_r,
  input wire [7:0] reset_latched_port_high_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // mode code and its source field
  code_field_a: assert property (clk_valid_r |-> clock_gen_code_r == reset_latched_port_high_r[7:5])
    else $error("code differs from latched field");
  code_fixed_a: assert property (clk_valid_r |=> $stable(clock_gen_code_r) && $stable(reset_latched_port_high_r))
    else $error("captured code changed");
  clk_idle_a: assert property (!clk_valid_r |-> !cpu_clk_r)
    else $error("cpu clock ran before valid");
  tick_edge_a: assert property (half_cycle_tick_r == (cpu_clk_r != $past(cpu_clk_r)))
    else $error("tick not on a cpu clock edge");
  // path selection against the code
  direct_mode_a: assert property (clk_valid_r |-> direct_drive_r == (clock_gen_code_r == 3'h3))
    else $error("direct path wrong");
  presc_mode_a: assert property (clk_valid_r |-> prescaler_on_r == (clock_gen_code_r == 3'h1))
    else $error("prescaler path wrong");
  pll_mode_a: assert property (clk_valid_r |-> pll_enable_r == (clock_gen_code_r != 3'h1 && clock_gen_code_r != 3'h3))
    else $error("pll enable wrong");
  // waveform relations
  direct_follow_a: assert property (direct_drive_r && $past(clk_valid_r, 4) |-> cpu_clk_r == $past(osc_in, 3))
    else $error("direct clock does not follow oscillator");
  presc_step_a: assert property (prescaler_on_r && clk_valid_r && $rose(osc_in) |-> ##3 half_cycle_tick_r)
    else $error("prescaler edge missing");
  // bus answers at once and always okay
  bus_okay_a: assert property (hreadyout_r && !hresp_r)
    else $error("bus not ready or not okay");
endmodule
bind ccm_clock_select ccm_cs_sva u_sva (
  .clk(clk),
  .rst_n(rst_n),
  .osc_in(osc_in),
  .hreadyout_r(hreadyout_r),
  .hresp_r(hresp_r),
  .cpu_clk_r(cpu_clk_r),
  .half_cycle_tick_r(half_cycle_tick_r),
  .pll_enable_r(pll_enable_r),
  .direct_drive_r(direct_drive_r),
  .prescaler_on_r(prescaler_on_r),
  .clk_valid_r(clk_valid_r),
  .clock_gen_code_r(clock_gen_code_r),
  .reset_latched_port_high_r(reset_latched_port_high_r)
);

// ==== ccm_defs.vh ====
`ifndef CCM_DEFS_VH
`define CCM_DEFS_VH

// clock generation codes held in the captured port field
`define CCM_CODE_X2P5 3'h0
`define CCM_CODE_PRESC 3'h1
`define CCM_CODE_X1P5 3'h2
`define CCM_CODE_DIRECT 3'h3
`define CCM_CODE_X5 3'h4
`define CCM_CODE_X2 3'h5
`define CCM_CODE_X3 3'h6
`define CCM_CODE_X4 3'h7

// pll factors expressed in halves (cpu edges per oscillator period)
`define CCM_HX_X1P5 4'h3
`define CCM_HX_X2 4'h4
`define CCM_HX_X2P5 4'h5
`define CCM_HX_X3 4'h6
`define CCM_HX_X4 4'h8
`define CCM_HX_X5 4'ha

// code field inside the reset-latched port register
`define CCM_CFG_MSB 7
`define CCM_CFG_LSB 5

// register byte offsets
`define CCM_OFS_STATUS 8'h00
`define CCM_OFS_BUSCFG 8'h04
`define CCM_OFS_TIMING 8'h08
`define CCM_OFS_PERIOD 8'h0c
`define CCM_OFS_CMD 8'h10

// bus config fields and reset value (zero waitstates, no extension)
`define CCM_CYC_LSB 0
`define CCM_CYC_MSB 3
`define CCM_TRI_BIT 4
`define CCM_ALE_BIT 5
`define CCM_BUSCFG_RST 6'h1f
`define CCM_CYC_FULL 4'hf

// status fields
`define CCM_ST_VALID 3
`define CCM_ST_PLL 4
`define CCM_ST_DIRECT 5
`define CCM_ST_PRESC 6
`define CCM_ST_LOCK 7

// timing counts
`define CCM_CAPTURE_DLY 2'h3

`endif

// ==== ccm_osc_model.sv ====
`timescale 1ns/10ps
// oscillator pin source; period must stay at or above 20 system clocks
module ccm_osc_model #(
  parameter P = 20,
  parameter H = 7
) (
  input wire clk,
  output reg osc
);
  integer ph = 0;
  initial osc = 1'b0;
  // free-running square wave with an uneven duty cycle
  always @(posedge clk) begin
    ph <= (ph == P - 1) ? 0 : ph + 1;
    osc <= (ph < H);
  end
endmodule

// ==== ccm_tcl_timer.v ====
`timescale 1ns/10ps
// counts a number of cpu half-cycles, then gives one done pulse
module ccm_half_timer #(
  parameter W = 5
) (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire [W-1:0] load,
  input wire tick,
  output reg busy_r,
  output reg done_r
);

  reg [W-1:0] cnt_r;

  // countdown on each cpu edge; zero load finishes at once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {W{1'b0}};
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (start) begin
      cnt_r <= load;
      busy_r <= (load != {W{1'b0}});
      done_r <= (load == {W{1'b0}});
    end else if (busy_r && tick) begin
      cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      busy_r <= (cnt_r != {{(W-1){1'b0}}, 1'b1});
      done_r <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
    end else begin
      done_r <= 1'b0;
    end
  end

endmodule
